// *** src/rtc_defines.svh ***
// Register offsets, field positions, reset values and counts of the RTC core
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// Serial slave address: arbitrary value, change per board
`define RTC_SLAVE_ADDR   7'h3A

`define RTC_REG_SEC      4'h0
`define RTC_REG_MIN      4'h1
`define RTC_REG_HOUR     4'h2
`define RTC_REG_WDAY     4'h3
`define RTC_REG_DATE     4'h4
`define RTC_REG_MONTH    4'h5
`define RTC_REG_YEAR     4'h6
`define RTC_REG_A1SEC    4'h7
`define RTC_REG_A1MIN    4'h8
`define RTC_REG_A1HOUR   4'h9
`define RTC_REG_A1DD     4'hA
`define RTC_REG_A2MIN    4'hB
`define RTC_REG_A2HOUR   4'hC
`define RTC_REG_A2DD     4'hD
`define RTC_REG_CTRL     4'hE
`define RTC_REG_FLAGS    4'hF

`define RTC_CTL_HALT     7
`define RTC_CTL_RS_HI    4
`define RTC_CTL_RS_LO    3
`define RTC_CTL_ROUTE    2
`define RTC_CTL_IE2      1
`define RTC_CTL_IE1      0
`define RTC_STS_OSF      7
`define RTC_STS_F2       1
`define RTC_STS_F1       0
`define RTC_ALM_MASK     7
`define RTC_ALM_DYDT     6
`define RTC_HR_12        6
`define RTC_HR_PM        5
`define RTC_MON_CENT     7

`define RTC_CTRL_RST     8'h18
`define RTC_FLAGS_RST    8'h80
`define RTC_BCD_ONE      8'h01

`define RTC_SEC_MAX      7'h59
`define RTC_HR12_MAX     5'h12
`define RTC_HR12_PRE     5'h11
`define RTC_HR24_MAX     6'h23
`define RTC_WD_MAX       3'h7
`define RTC_MON_MAX      5'h12
`define RTC_YEAR_MAX     8'h99

// Oscillator divided down to the one-second tick
`define RTC_OSC_HZ       32768
`define RTC_DIV_TOP      15'h7FFF
`define RTC_WAVE_1HZ     14
`define RTC_WAVE_4K      2
`define RTC_WAVE_8K      1
`define RTC_BITS_BYTE    4'h8

`endif

// *** src/rtc_pkg.sv ***
// Types shared by the RTC core
package rtc_pkg;

  typedef enum logic [3:0] {
    RTC_IDLE,
    RTC_ADDR,
    RTC_ACK_ADDR,
    RTC_PTR,
    RTC_ACK_PTR,
    RTC_WR,
    RTC_ACK_WR,
    RTC_RD,
    RTC_RD_ACK,
    RTC_RD_GO
  } rtc_phase_t;

  typedef struct packed {
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic [1:0]        osc_sync;
    logic              scl_prev;
    logic              sda_prev;
    logic              osc_prev;
    rtc_phase_t        phase;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic              rw;
    logic [3:0]        ptr;
    logic              sda_oe;
    logic [15:0][7:0]  regs;
    logic [6:0][7:0]   snap;
    logic [14:0]       div;
    logic              prim_oe;
    logic              sec_oe;
  } rtc_state_t;

endpackage

// *** src/rtc_core.sv ***
// Clock/calendar core with two alarms behind a two-wire serial slave
//
// Functional notes
// - Pointer increments per byte, wraps 0Fh to 00h
// - Snapshot time on START, STOP, pointer wrap
// - Time and calendar kept in packed BCD
// - Weekday counts 1 to 7, advances at midnight
// - Seconds write clears the sub-second divider
// - Written byte commits at its acknowledge bit
// - 1Hz wave rises 500ms after seconds write
// - Hours bit 6 selects 12-hour format
// - Bit 5 is afternoon or twenty-hours digit
// - Century bit toggles on year 99 to 00
// - Alarm 1 at 07h-0Ah, alarm 2 at 0Bh-0Dh
// - All masks zero: alarm needs full match
// - Day/date bit 6 picks weekday or date
// - Unmasked match sets the alarm flag
// - Flag stays set until software writes zero
// - Enabled set flag drives the interrupt low
// - Route bit: separate or shared interrupt pins
// - Alarms compared only at the second update
// - Alarm 1 mask patterns set repeat rate
// - Alarm 2 mask patterns, fires at second 00
// - Route one splits pins, zero outputs wave
// - Rate bits pick 1Hz to 32.768kHz wave
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_core (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic osc_i,
  output logic      primary_irq_n_o,
  output logic      primary_irq_n_oe_o,
  output logic      wave_or_secondary_irq_n_o,
  output logic      wave_or_secondary_irq_n_oe_o
);

  rtc_pkg::rtc_state_t st;
  rtc_pkg::rtc_state_t nx;

  logic       scl_s;
  logic       sda_s;
  logic       osc_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       osc_rise;
  logic       start_det;
  logic       stop_det;
  logic       tick;
  logic       ptr_adv;
  logic       sec_wr;
  logic       a1_hit;
  logic       a2_hit;
  logic       wave;
  logic [6:0][7:0] tnew;
  logic [7:0] rd_val;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] days_in_month(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: days_in_month = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction

  // One-second advance of the whole calendar, carries rippling upward
  function automatic logic [6:0][7:0] adv_time(input logic [6:0][7:0] t);
    logic [6:0][7:0] r;
    logic            c;
    r = t;
    c = 1'b0;
    if (t[0][6:0] == `RTC_SEC_MAX) begin
      r[0] = 8'h00;
      c = 1'b1;
    end else begin
      r[0] = bcd_inc(t[0]);
    end
    if (c) begin
      c = 1'b0;
      if (t[1][6:0] == `RTC_SEC_MAX) begin
        r[1] = 8'h00;
        c = 1'b1;
      end else begin
        r[1] = bcd_inc(t[1]);
      end
    end
    if (c) begin
      c = 1'b0;
      if (t[2][`RTC_HR_12]) begin
        if (t[2][4:0] == `RTC_HR12_MAX) begin
          r[2] = {t[2][7:5], 5'h01};
        end else if (t[2][4:0] == `RTC_HR12_PRE) begin
          // Eleven to twelve flips the half-day; 11PM to 12AM is midnight
          r[2] = {t[2][7:6], ~t[2][`RTC_HR_PM], `RTC_HR12_MAX};
          c = t[2][`RTC_HR_PM];
        end else begin
          r[2] = {t[2][7:5], 5'(bcd_inc({3'h0, t[2][4:0]}))};
        end
      end else if (t[2][5:0] == `RTC_HR24_MAX) begin
        r[2] = {t[2][7:6], 6'h00};
        c = 1'b1;
      end else begin
        r[2] = {t[2][7:6], 6'h00} | bcd_inc({2'h0, t[2][5:0]});
      end
    end
    if (c) begin
      r[3] = (t[3][2:0] == `RTC_WD_MAX) ? `RTC_BCD_ONE : t[3] + 8'h01;
      c = 1'b0;
      if (t[4] == days_in_month(t[5][4:0], t[6])) begin
        r[4] = `RTC_BCD_ONE;
        c = 1'b1;
      end else begin
        r[4] = bcd_inc(t[4]);
      end
    end
    if (c) begin
      c = 1'b0;
      if (t[5][4:0] == `RTC_MON_MAX) begin
        r[5] = {t[5][7:5], 5'h01};
        c = 1'b1;
      end else begin
        r[5] = {t[5][7:5], 5'h00} | bcd_inc({3'h0, t[5][4:0]});
      end
    end
    if (c) begin
      if (t[6] == `RTC_YEAR_MAX) begin
        r[6] = 8'h00;
        r[5][`RTC_MON_CENT] = ~r[5][`RTC_MON_CENT];
      end else begin
        r[6] = bcd_inc(t[6]);
      end
    end
    adv_time = r;
  endfunction

  // Masked field compare; bit 7 of every alarm byte is its mask
  function automatic logic field_hit(input logic [7:0] a, input logic [7:0] v);
    field_hit = a[`RTC_ALM_MASK] | (a[6:0] == v[6:0]);
  endfunction

  function automatic logic dd_hit(input logic [7:0] a, input logic [7:0] wd,
                                  input logic [7:0] dt);
    logic [7:0] v;
    v = a[`RTC_ALM_DYDT] ? wd : dt;
    dd_hit = a[`RTC_ALM_MASK] | (a[5:0] == v[5:0]);
  endfunction

  function automatic logic [7:0] wr_mask(input logic [3:0] p);
    case (p)
      `RTC_REG_SEC, `RTC_REG_MIN, `RTC_REG_HOUR: wr_mask = 8'h7F;
      `RTC_REG_WDAY:  wr_mask = 8'h07;
      `RTC_REG_DATE:  wr_mask = 8'h3F;
      `RTC_REG_MONTH: wr_mask = 8'h9F;
      `RTC_REG_CTRL:  wr_mask = 8'h9F;
      default:        wr_mask = 8'hFF;
    endcase
  endfunction

  assign scl_s     = st.scl_sync[1];
  assign sda_s     = st.sda_sync[1];
  assign osc_s     = st.osc_sync[1];
  assign scl_rise  = scl_s & ~st.scl_prev;
  assign scl_fall  = ~scl_s & st.scl_prev;
  assign osc_rise  = osc_s & ~st.osc_prev;
  assign start_det = scl_s & st.scl_prev & st.sda_prev & ~sda_s;
  assign stop_det  = scl_s & st.scl_prev & ~st.sda_prev & sda_s;
  // Time bytes come from the snapshot so a read never tears
  assign rd_val    = (st.ptr <= `RTC_REG_YEAR) ? st.snap[st.ptr[2:0]] : st.regs[st.ptr];
  assign tnew      = adv_time(st.regs[6:0]);

  always_comb begin
    nx = st;
    tick = 1'b0;
    ptr_adv = 1'b0;
    sec_wr = 1'b0;
    a1_hit = 1'b0;
    a2_hit = 1'b0;
    nx.scl_sync = {st.scl_sync[0], scl_i};
    nx.sda_sync = {st.sda_sync[0], sda_i};
    nx.osc_sync = {st.osc_sync[0], osc_i};
    nx.scl_prev = scl_s;
    nx.sda_prev = sda_s;
    nx.osc_prev = osc_s;

    if (osc_rise && !st.regs[`RTC_REG_CTRL][`RTC_CTL_HALT]) begin
      nx.div = st.div + 15'h0001;
      tick = (st.div == `RTC_DIV_TOP);
    end
    if (tick) begin
      nx.regs[6:0] = tnew;
      // Compare against the freshly updated time only
      a1_hit = field_hit(st.regs[`RTC_REG_A1SEC], tnew[0])
             & field_hit(st.regs[`RTC_REG_A1MIN], tnew[1])
             & field_hit(st.regs[`RTC_REG_A1HOUR], tnew[2])
             & dd_hit(st.regs[`RTC_REG_A1DD], tnew[3], tnew[4]);
      a2_hit = (tnew[0] == 8'h00)
             & field_hit(st.regs[`RTC_REG_A2MIN], tnew[1])
             & field_hit(st.regs[`RTC_REG_A2HOUR], tnew[2])
             & dd_hit(st.regs[`RTC_REG_A2DD], tnew[3], tnew[4]);
    end

    if (start_det || stop_det) begin
      nx.snap = st.regs[6:0];
      nx.sda_oe = 1'b0;
      nx.bit_cnt = 4'h0;
      nx.phase = start_det ? rtc_pkg::RTC_ADDR : rtc_pkg::RTC_IDLE;
    end else begin
      case (st.phase)
        rtc_pkg::RTC_ADDR, rtc_pkg::RTC_PTR, rtc_pkg::RTC_WR: begin
          if (scl_rise) begin
            nx.shreg = {st.shreg[6:0], sda_s};
            nx.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall && st.bit_cnt == `RTC_BITS_BYTE) begin
            nx.sda_oe = 1'b1;
            if (st.phase == rtc_pkg::RTC_ADDR) begin
              nx.rw = st.shreg[0];
              nx.sda_oe = (st.shreg[7:1] == `RTC_SLAVE_ADDR);
              nx.phase = nx.sda_oe ? rtc_pkg::RTC_ACK_ADDR : rtc_pkg::RTC_IDLE;
            end else if (st.phase == rtc_pkg::RTC_PTR) begin
              nx.ptr = st.shreg[3:0];
              nx.phase = rtc_pkg::RTC_ACK_PTR;
            end else begin
              // Commit while the acknowledge is being driven
              ptr_adv = 1'b1;
              sec_wr = (st.ptr == `RTC_REG_SEC);
              if (st.ptr == `RTC_REG_FLAGS) begin
                nx.regs[st.ptr] = st.regs[st.ptr] & {st.shreg[7], 5'h00, st.shreg[1:0]};
              end else begin
                nx.regs[st.ptr] = st.shreg & wr_mask(st.ptr);
              end
              nx.phase = rtc_pkg::RTC_ACK_WR;
            end
          end
        end
        rtc_pkg::RTC_ACK_ADDR, rtc_pkg::RTC_RD_GO: begin
          if (scl_fall) begin
            nx.bit_cnt = 4'h0;
            if (st.rw) begin
              nx.shreg = rd_val;
              nx.sda_oe = ~rd_val[7];
              nx.phase = rtc_pkg::RTC_RD;
            end else begin
              nx.sda_oe = 1'b0;
              nx.phase = rtc_pkg::RTC_PTR;
            end
          end
        end
        rtc_pkg::RTC_ACK_PTR, rtc_pkg::RTC_ACK_WR: begin
          if (scl_fall) begin
            nx.sda_oe = 1'b0;
            nx.bit_cnt = 4'h0;
            nx.phase = rtc_pkg::RTC_WR;
          end
        end
        rtc_pkg::RTC_RD: begin
          if (scl_rise) begin
            nx.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bit_cnt == `RTC_BITS_BYTE) begin
              nx.sda_oe = 1'b0;
              ptr_adv = 1'b1;
              nx.phase = rtc_pkg::RTC_RD_ACK;
            end else begin
              nx.shreg = {st.shreg[6:0], 1'b0};
              nx.sda_oe = ~st.shreg[6];
            end
          end
        end
        rtc_pkg::RTC_RD_ACK: begin
          // A not-acknowledge ends the read; wait for STOP or START
          if (scl_rise) begin
            nx.phase = sda_s ? rtc_pkg::RTC_IDLE : rtc_pkg::RTC_RD_GO;
          end
        end
        default: begin
          nx.sda_oe = 1'b0;
        end
      endcase
    end

    if (ptr_adv) begin
      nx.ptr = st.ptr + 4'h1;
      if (st.ptr == `RTC_REG_FLAGS) begin
        nx.snap = nx.regs[6:0];
      end
    end
    if (sec_wr) begin
      nx.div = 15'h0000;
    end

    // Hardware sets after any software clear so a same-cycle event survives
    if (a1_hit) begin
      nx.regs[`RTC_REG_FLAGS][`RTC_STS_F1] = 1'b1;
    end
    if (a2_hit) begin
      nx.regs[`RTC_REG_FLAGS][`RTC_STS_F2] = 1'b1;
    end
    if (nx.regs[`RTC_REG_CTRL][`RTC_CTL_HALT]) begin
      nx.regs[`RTC_REG_FLAGS][`RTC_STS_OSF] = 1'b1;
    end

    case ({nx.regs[`RTC_REG_CTRL][`RTC_CTL_RS_HI], nx.regs[`RTC_REG_CTRL][`RTC_CTL_RS_LO]})
      2'b00:   wave = nx.div[`RTC_WAVE_1HZ];
      2'b01:   wave = nx.div[`RTC_WAVE_4K];
      2'b10:   wave = nx.div[`RTC_WAVE_8K];
      default: wave = osc_s;
    endcase
    nx.prim_oe = (nx.regs[`RTC_REG_FLAGS][`RTC_STS_F1] & nx.regs[`RTC_REG_CTRL][`RTC_CTL_IE1])
               | (~nx.regs[`RTC_REG_CTRL][`RTC_CTL_ROUTE]
                  & nx.regs[`RTC_REG_FLAGS][`RTC_STS_F2]
                  & nx.regs[`RTC_REG_CTRL][`RTC_CTL_IE2]);
    nx.sec_oe = nx.regs[`RTC_REG_CTRL][`RTC_CTL_ROUTE]
              ? (nx.regs[`RTC_REG_FLAGS][`RTC_STS_F2] & nx.regs[`RTC_REG_CTRL][`RTC_CTL_IE2])
              : ~wave;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.scl_sync <= 2'b11;
      st.sda_sync <= 2'b11;
      st.scl_prev <= 1'b1;
      st.sda_prev <= 1'b1;
      st.regs[`RTC_REG_WDAY] <= `RTC_BCD_ONE;
      st.regs[`RTC_REG_DATE] <= `RTC_BCD_ONE;
      st.regs[`RTC_REG_MONTH] <= `RTC_BCD_ONE;
      st.regs[`RTC_REG_CTRL] <= `RTC_CTRL_RST;
      st.regs[`RTC_REG_FLAGS] <= `RTC_FLAGS_RST;
    end else begin
      st <= nx;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = st.sda_oe;
  assign primary_irq_n_o = 1'b0;
  assign primary_irq_n_oe_o = st.prim_oe;
  assign wave_or_secondary_irq_n_o = 1'b0;
  assign wave_or_secondary_irq_n_oe_o = st.sec_oe;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_start;
    scl_s && st.scl_prev && st.sda_prev && !sda_s;
  endsequence

  sequence s_wr_byte_done;
    st.phase == rtc_pkg::RTC_WR && scl_fall && st.bit_cnt == `RTC_BITS_BYTE;
  endsequence

  property p_ptr_wrap;
    (ptr_adv && st.ptr == `RTC_REG_FLAGS) |=> (st.ptr == `RTC_REG_SEC && st.snap == st.regs[6:0]);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap with snapshot");

  property p_start_snap;
    s_start |=> (st.snap == $past(st.regs[6:0]) && st.phase == rtc_pkg::RTC_ADDR);
  endproperty
  a_start_snap: assert property (p_start_snap) else $error("no snapshot at start");

  property p_sec_wrap;
    (tick && !sec_wr && st.regs[`RTC_REG_SEC] == 8'h59) |=> (st.regs[`RTC_REG_SEC] == 8'h00);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");

  property p_div_clear;
    s_wr_byte_done ##0 (st.ptr == `RTC_REG_SEC) |=> (st.div == 15'h0000);
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared");

  property p_wr_ack;
    s_wr_byte_done |=> (st.sda_oe && st.phase == rtc_pkg::RTC_ACK_WR && st.ptr == $past(st.ptr) + 4'h1);
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");

  property p_century;
    (tick && st.regs[`RTC_REG_YEAR] == 8'h99 && tnew[6] == 8'h00)
      |=> (st.regs[`RTC_REG_MONTH][7] != $past(st.regs[`RTC_REG_MONTH][7]));
  endproperty
  a_century: assert property (p_century) else $error("century bit not toggled");

  property p_flag_sticky;
    (st.regs[`RTC_REG_FLAGS][0] && !(st.phase == rtc_pkg::RTC_WR && scl_fall))
      |=> st.regs[`RTC_REG_FLAGS][0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("alarm flag dropped");

  property p_flag_only_tick;
    $rose(st.regs[`RTC_REG_FLAGS][0]) |-> $past(tick);
  endproperty
  a_flag_only_tick: assert property (p_flag_only_tick) else $error("flag set off tick");

  property p_irq_drive;
    (st.regs[`RTC_REG_FLAGS][0] && st.regs[`RTC_REG_CTRL][0]) |-> primary_irq_n_oe_o;
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt not driven");

  property p_wave_pin;
    (!st.regs[`RTC_REG_CTRL][2] && st.regs[`RTC_REG_CTRL][4:3] == 2'b00)
      |-> (wave_or_secondary_irq_n_oe_o == !st.div[14]);
  endproperty
  a_wave_pin: assert property (p_wave_pin) else $error("wave pin wrong");

endmodule

// *** sim/rtc_bus_master.sv ***
// Two-wire bus master model for the RTC core's serial port
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_bus_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One clock pulse; the wire is taken late in the high phase
  task automatic pulse(input logic b, output logic seen);
    sda_low_o = ~b;
    pause(5);
    scl_o = 1'b1;
    pause(6);
    seen = sda_i;
    scl_o = 1'b0;
    pause(1);
  endtask

  task automatic start();
    logic seen;
    sda_low_o = 1'b0;
    pause(5);
    // A stuck slave is clocked out before the START
    for (int i = 0; i < 9 && sda_i !== 1'b1; i++) pulse(1'b1, seen);
    scl_o = 1'b1;
    pause(6);
    sda_low_o = 1'b1;
    pause(6);
    scl_o = 1'b0;
    pause(1);
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    pause(5);
    scl_o = 1'b1;
    pause(6);
    sda_low_o = 1'b0;
    pause(6);
  endtask

  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) pulse(d[i], seen);
    pulse(1'b1, seen);
    ack = ~seen;
  endtask

  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic seen;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(last, seen);
  endtask

  task automatic write_frame(input logic [6:0] addr, input logic [7:0] ptr,
                             input logic [7:0] data[$], output logic acked);
    logic a;
    start();
    tx_byte({addr, 1'b0}, a);
    acked = a;
    if (a) begin
      tx_byte(ptr, a);
      acked = acked & a;
      foreach (data[i]) begin
        tx_byte(data[i], a);
        acked = acked & a;
      end
    end
    stop();
  endtask

  task automatic read_frame(input logic [7:0] ptr, input int n, output logic [7:0] got[$]);
    logic       a;
    logic [7:0] d;
    got = {};
    start();
    tx_byte({`RTC_SLAVE_ADDR, 1'b0}, a);
    tx_byte(ptr, a);
    start();
    tx_byte({`RTC_SLAVE_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      rx_byte(i == n - 1, d);
      got.push_back(d);
    end
    stop();
  endtask
endmodule

// *** sim/rtc_calendar_alarm_core_bench.sv ***
// Self-checking bench for the RTC core driven by the bus master model
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_calendar_alarm_core_bench;
  logic clk_i;
  logic rst_b_i;
  logic osc_i;
  logic scl;
  logic sda_low;
  logic sda_w;
  logic sda_o;
  logic sda_oe;
  logic prim_o;
  logic prim_oe;
  logic sec_o;
  logic sec_oe;
  int   bad_count;
  int   total_checks;

  // Pull-up on the data wire
  assign sda_w = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  rtc_core uut (
    .clk_i                        (clk_i),
    .rst_b_i                      (rst_b_i),
    .scl_i                        (scl),
    .sda_i                        (sda_w),
    .sda_o                        (sda_o),
    .sda_oe_o                     (sda_oe),
    .osc_i                        (osc_i),
    .primary_irq_n_o              (prim_o),
    .primary_irq_n_oe_o           (prim_oe),
    .wave_or_secondary_irq_n_o    (sec_o),
    .wave_or_secondary_irq_n_oe_o (sec_oe)
  );

  rtc_bus_master master (
    .clk_i     (clk_i),
    .sda_i     (sda_w),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Fast oscillator, two clocks a period, keeps one second near 65.5k clocks
  initial begin
    osc_i = 1'b0;
    forever #10 osc_i = ~osc_i;
  end

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic test_reset_map();
    logic [7:0] got[$];
    logic [7:0] exp[$];
    exp = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, `RTC_CTRL_RST, `RTC_FLAGS_RST, 8'h00};
    check_bit("irq idle", 1'b0, prim_oe);
    check_bit("pin drive levels", 1'b0, sda_o | prim_o | sec_o);
    master.read_frame(8'h00, 17, got);
    foreach (exp[i]) check_byte($sformatf("reg %0d", i), exp[i], got[i]);
  endtask

  task automatic test_refusals();
    logic       ok;
    logic [7:0] got[$];
    master.write_frame(7'h3B, 8'h0E, '{8'h07}, ok);
    check_bit("foreign address ack", 1'b0, ok);
    master.write_frame(`RTC_SLAVE_ADDR, 8'h0F, '{8'hFF}, ok);
    master.read_frame(8'h0E, 2, got);
    check_byte("control kept", `RTC_CTRL_RST, got[0]);
    check_byte("flags kept", `RTC_FLAGS_RST, got[1]);
  endtask

  task automatic test_alarm_map();
    logic       ok;
    logic [7:0] got[$];
    logic [7:0] cfg[$];
    // Alarm 1 on weekday 1 at 12 AM, alarm 2 on date 01 at 12 AM, 12-hour, pins split
    cfg = '{8'h00, 8'h00, 8'h52, 8'h41, 8'h00, 8'h52, 8'h01, 8'h07};
    master.write_frame(`RTC_SLAVE_ADDR, 8'h07, cfg, ok);
    check_bit("alarm write ack", 1'b1, ok);
    master.read_frame(8'h07, 8, got);
    foreach (cfg[i]) check_byte($sformatf("alarm reg %0d", i + 7), cfg[i], got[i]);
  endtask

  task automatic test_midnight_tick();
    logic       ok;
    int         n;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    exp = '{8'h83, 8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h81, 8'h00};
    // 11:59:59 PM in 12-hour format, last day of the century
    master.write_frame(`RTC_SLAVE_ADDR, 8'h00,
                       '{8'h59, 8'h59, 8'h71, 8'h07, 8'h31, 8'h12, 8'h99}, ok);
    check_bit("early alarm", 1'b0, prim_oe);
    n = 0;
    while (prim_oe !== 1'b1 && n < 70000) begin
      @(negedge clk_i);
      n++;
    end
    // 32768 oscillator periods of 2 clocks; seconds byte committed ~675 clocks before return
    check_bit("tick spacing", 1'b1, n > 64500 && n < 65200);
    check_bit("alarm 2 pin", 1'b1, sec_oe);
    master.read_frame(8'h0F, 8, got);
    foreach (exp[i]) check_byte($sformatf("after tick %0d", i), exp[i], got[i]);
  endtask

  task automatic test_flag_clear();
    logic       ok;
    logic [7:0] got[$];
    master.write_frame(`RTC_SLAVE_ADDR, 8'h0F, '{8'h02}, ok);
    check_bit("alarm 1 cleared", 1'b0, prim_oe);
    check_bit("alarm 2 held", 1'b1, sec_oe);
    master.read_frame(8'h0F, 1, got);
    check_byte("flags after clear", 8'h02, got[0]);
    master.write_frame(`RTC_SLAVE_ADDR, 8'h0E, '{8'h02}, ok);
    check_bit("shared pin", 1'b1, prim_oe);
    master.write_frame(`RTC_SLAVE_ADDR, 8'h0E, '{8'h00}, ok);
    check_bit("alarm 2 disabled", 1'b0, prim_oe);
  endtask

  // Wave pin on route zero: rises counted over a window of whole periods
  task automatic test_wave_rates();
    logic ok;
    logic prev;
    int   n;
    int   exp_n;
    for (int rs = 1; rs < 4; rs++) begin
      master.write_frame(`RTC_SLAVE_ADDR, 8'h0E, '{8'(rs << `RTC_CTL_RS_LO)}, ok);
      // 4.096k, 8.192k, 32.768k: 8, 4, 1 oscillator periods of 2 clocks
      exp_n = 160 / (2 * (rs == 1 ? 8 : (rs == 2 ? 4 : 1)));
      n = 0;
      prev = sec_oe;
      repeat (160) begin
        @(negedge clk_i);
        if (sec_oe === 1'b1 && prev === 1'b0) n++;
        prev = sec_oe;
      end
      check_byte("wave rises", 8'(exp_n), 8'(n));
    end
  endtask

  initial begin
    #1000000;
    bad_count++;
    conclude();
  end

  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_b_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    test_reset_map();
    test_refusals();
    test_alarm_map();
    test_midnight_tick();
    test_flag_clear();
    test_wave_rates();
    conclude();
  end
endmodule
